//--- rtl/uhep_defs.svh
// constants for the host endpoint 0 and transmit endpoint control block
`ifndef UHEP_DEFS_SVH
`define UHEP_DEFS_SVH
`define UHEP_ADDR_EP0_CTRL_HI 9'h103
`define UHEP_ADDR_EP0_COUNT 9'h108
`define UHEP_ADDR_EP0_SPEED 9'h10a
`define UHEP_ADDR_EP0_NAKLIM 9'h10b
`define UHEP_ADDR_TX1_CTRL_LO 9'h112
`define UHEP_ADDR_TX2_CTRL_LO 9'h122
`define UHEP_ADDR_TX3_CTRL_LO 9'h132
`define UHEP_ADDR_TX_STRIDE 9'h010
`define UHEP_BIT_NAK_EXPIRY_HALT 3'd7
`define UHEP_BIT_CLRTOG 3'd6
`define UHEP_BIT_STALL 3'd5
`define UHEP_BIT_SETUP 3'd4
`define UHEP_BIT_FLUSH 3'd3
`define UHEP_BIT_ERROR 3'd2
`define UHEP_BIT_FIFO_HAS_PACKET 3'd1
`define UHEP_BIT_LOADED 3'd0
`define UHEP_SPEED_FULL 2'h2
`define UHEP_SPEED_LOW 2'h3
`define UHEP_NAKLIM_MIN 5'h02
`define UHEP_NAKLIM_MAX 5'h10
`define UHEP_RESET_BYTE 8'h00
`define UHEP_RETRY_LIMIT 2'h3
`endif

//--- rtl/uhep_pkg.sv
// types shared by the host endpoint 0 and transmit endpoint control block
package uhep_pkg;
   // link events reported for one transmit endpoint
   typedef struct packed {
      logic sent;    // packet transmitted and acknowledged
      logic nak;     // NAK handshake received
      logic stall;   // STALL handshake received
      logic no_hs;   // attempt ended without handshake
      logic bulk;    // endpoint works in bulk mode
      logic intr;    // endpoint works in interrupt mode
   } uhep_txev_s;
   // commands from the block toward one transmit endpoint datapath
   typedef struct packed {
      logic send;        // packet waiting to be sent
      logic setup_tok;   // send setup token instead of out
      logic flush;       // empty fifo pointer, one cycle
      logic tog_clr;     // clear the data toggle, one cycle
      logic dma_stop;    // stop dma request
      logic irq;         // transmit interrupt flag pulse
   } uhep_txcmd_s;
   // endpoint 0 speed decode
   typedef enum logic [1:0] {
      UHEP_SPD_RSV0 = 2'h0,
      UHEP_SPD_RSV1 = 2'h1,
      UHEP_SPD_FULL = 2'h2,
      UHEP_SPD_LOW = 2'h3
   } uhep_speed_e;
   // endpoint 0 flush sequence
   typedef enum logic [1:0] {
      UHEP_F_IDLE = 2'b00,
      UHEP_F_DROP = 2'b01,
      UHEP_F_DONE = 2'b11
   } uhep_fl_e;
endpackage

//--- rtl/uhep_ctrl.sv
// host endpoint 0 and transmit endpoint 1 to 3 control and status logic
`timescale 1ns/1ps
`include "uhep_defs.svh"
module uhep_ctrl
(
   input wire logic CLK_SYS,
   input wire logic SRST,
   input wire logic [8:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic [6:0] EP0_FIFO_LEVEL,
   input wire logic EP0_TX_READY,
   input wire logic EP0_RX_READY,
   input wire logic EP0_NAK,
   input wire logic EP0_ACK,
   input wire logic FRAME_TICK,
   output logic EP0_FLUSH,
   output logic EP0_HALT,
   output uhep_pkg::uhep_speed_e EP0_SPEED,
   input wire uhep_pkg::uhep_txev_s [2:0] TX_EV,
   input wire logic [2:0] TX_FIFO_NONEMPTY,
   output uhep_pkg::uhep_txcmd_s [2:0] TX_CMD
);
   import uhep_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // endpoint 0 state
   logic [1:0] speed_ff;           // target speed field
   logic [4:0] naklim_ff;          // nak limit field m
   logic [16:0] nak_frames_ff;     // frames with nak only
   logic nak_in_frame_ff;          // nak seen in current frame
   logic halt_ff;                  // endpoint 0 halted
   logic [6:0] count_ff;           // received byte count
   uhep_fl_e fl_ff;                // discard sequence state
   logic flush_ff;                 // discard pulse toward fifo
   logic [7:0] rdata_ff;           // read data register
   logic [16:0] nak_limit;         // limit in frames
   logic nak_enable;               // timeout active

   // write decodes
   logic wr_ep0hi;
   logic wr_speed;
   logic wr_naklim;
   assign wr_ep0hi = WR && (ADDR == `UHEP_ADDR_EP0_CTRL_HI);
   assign wr_speed = WR && (ADDR == `UHEP_ADDR_EP0_SPEED);
   assign wr_naklim = WR && (ADDR == `UHEP_ADDR_EP0_NAKLIM);

   // limit decode: 2^(m-1) frames, off for 0 and 1, 16 is the top
   assign nak_enable = (naklim_ff >= `UHEP_NAKLIM_MIN);
   assign nak_limit = nak_enable ? (17'h00001 << (naklim_ff - 5'h01)) : 17'h00000;

   ////////////////////////////////////////////////////////////////////////////
   // speed and limit registers, reserved bits dropped
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         speed_ff <= 2'h0;
         naklim_ff <= 5'h00;
      end
      else
      begin
         if (wr_speed)
            speed_ff <= WDATA[7:6];
         if (wr_naklim)
            naklim_ff <= (WDATA[4:0] > `UHEP_NAKLIM_MAX) ? `UHEP_NAKLIM_MAX : WDATA[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // nak frame counting and halt of endpoint 0
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         nak_frames_ff <= 17'h00000;
         nak_in_frame_ff <= 1'b0;
         halt_ff <= 1'b0;
      end
      else
      begin
         // any other answer breaks the nak stream
         if (EP0_ACK || !nak_enable || wr_naklim)
         begin
            nak_frames_ff <= 17'h00000;
            nak_in_frame_ff <= 1'b0;
            halt_ff <= 1'b0;
         end
         else if (FRAME_TICK)
         begin
            // count a frame that held a nak
            if (nak_in_frame_ff || EP0_NAK)
               nak_frames_ff <= nak_frames_ff + 17'h00001;
            nak_in_frame_ff <= 1'b0;
            if ((nak_in_frame_ff || EP0_NAK) && (nak_frames_ff >= nak_limit))
               halt_ff <= 1'b1;
         end
         else if (EP0_NAK)
            nak_in_frame_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // endpoint 0 discard sequence, bit clears itself
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         fl_ff <= UHEP_F_IDLE;
         flush_ff <= 1'b0;
      end
      else
      begin
         unique case (fl_ff)
            UHEP_F_IDLE:
            begin
               flush_ff <= 1'b0;
               if (wr_ep0hi && WDATA[0])
               begin
                  fl_ff <= UHEP_F_DROP;
                  flush_ff <= 1'b1;
               end
            end
            UHEP_F_DROP:
            begin
               flush_ff <= 1'b0;
               fl_ff <= UHEP_F_DONE;
            end
            UHEP_F_DONE:
               fl_ff <= UHEP_F_IDLE;
            default:
               fl_ff <= UHEP_F_IDLE;
         endcase
      end
   end

   // byte count follows the fifo level
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
         count_ff <= 7'h00;
      else
         count_ff <= EP0_FIFO_LEVEL;
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit endpoints 1 to 3
   logic [7:0] txcsr_ff [3]; // low control bytes, one process per endpoint
   uhep_txcmd_s txcmd_ff [3]; // registered commands, one process per endpoint
   logic [1:0] retry_ff [3]; // failed attempts count

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_tx
         logic wr_me;
         logic [7:0] wd;
         logic stall_now;
         logic err_now;
         logic flush_now;
         logic sent_now;
         logic nak_expiry_halt_now;
         logic [8:0] my_addr;
         assign my_addr = 9'(`UHEP_ADDR_TX1_CTRL_LO + `UHEP_ADDR_TX_STRIDE * g);
         assign wr_me = WR && (ADDR == my_addr);
         assign wd = WDATA;
         assign stall_now = TX_EV[g].stall;
         assign err_now = TX_EV[g].no_hs && (TX_EV[g].bulk || TX_EV[g].intr)
                          && (retry_ff[g] == `UHEP_RETRY_LIMIT - 2'h1);
         assign flush_now = wr_me && wd[`UHEP_BIT_FLUSH];
         assign sent_now = TX_EV[g].sent && txcsr_ff[g][`UHEP_BIT_LOADED];
         assign nak_expiry_halt_now = TX_EV[g].nak && TX_EV[g].bulk && halt_ff;

         // control byte; hardware sets win over software clears
         always_ff @(posedge CLK_SYS)
         begin
            if (SRST)
               txcsr_ff[g] <= `UHEP_RESET_BYTE;
            else
            begin
               if (wr_me)
               begin
                  txcsr_ff[g][`UHEP_BIT_NAK_EXPIRY_HALT] <= wd[`UHEP_BIT_NAK_EXPIRY_HALT];
                  txcsr_ff[g][`UHEP_BIT_STALL] <= wd[`UHEP_BIT_STALL];
                  txcsr_ff[g][`UHEP_BIT_SETUP] <= wd[`UHEP_BIT_SETUP];
                  txcsr_ff[g][`UHEP_BIT_ERROR] <= wd[`UHEP_BIT_ERROR];
                  txcsr_ff[g][`UHEP_BIT_LOADED] <= wd[`UHEP_BIT_LOADED] && !flush_now;
               end
               txcsr_ff[g][`UHEP_BIT_CLRTOG] <= 1'b0;
               txcsr_ff[g][`UHEP_BIT_FLUSH] <= 1'b0;
               txcsr_ff[g][`UHEP_BIT_FIFO_HAS_PACKET] <= TX_FIFO_NONEMPTY[g];
               if (sent_now)
               begin
                  txcsr_ff[g][`UHEP_BIT_LOADED] <= 1'b0;
                  txcsr_ff[g][`UHEP_BIT_SETUP] <= 1'b0;
               end
               if (nak_expiry_halt_now)
                  txcsr_ff[g][`UHEP_BIT_NAK_EXPIRY_HALT] <= 1'b1;
               if (stall_now)
                  txcsr_ff[g][`UHEP_BIT_STALL] <= 1'b1;
               if (stall_now || txcsr_ff[g][`UHEP_BIT_STALL])
                  txcsr_ff[g][`UHEP_BIT_LOADED] <= 1'b0;
               if (err_now)
               begin
                  txcsr_ff[g][`UHEP_BIT_ERROR] <= 1'b1;
                  txcsr_ff[g][`UHEP_BIT_LOADED] <= 1'b0;
               end
            end
         end

         // failed attempt counter, restarted by any handshake
         always_ff @(posedge CLK_SYS)
         begin
            if (SRST || TX_EV[g].sent || TX_EV[g].nak || TX_EV[g].stall || err_now)
               retry_ff[g] <= 2'h0;
            else if (TX_EV[g].no_hs)
               retry_ff[g] <= retry_ff[g] + 2'h1;
         end

         // commands toward the endpoint datapath
         always_ff @(posedge CLK_SYS)
         begin
            if (SRST)
               txcmd_ff[g] <= '0;
            else
            begin
               txcmd_ff[g].send <= txcsr_ff[g][`UHEP_BIT_LOADED]
                                   && !txcsr_ff[g][`UHEP_BIT_NAK_EXPIRY_HALT];
               txcmd_ff[g].setup_tok <= txcsr_ff[g][`UHEP_BIT_SETUP];
               txcmd_ff[g].flush <= flush_now || stall_now || err_now;
               txcmd_ff[g].tog_clr <= wr_me && (wd[`UHEP_BIT_CLRTOG]
                                      || (wd[`UHEP_BIT_SETUP] && wd[`UHEP_BIT_LOADED]));
               txcmd_ff[g].dma_stop <= stall_now || txcsr_ff[g][`UHEP_BIT_STALL];
               txcmd_ff[g].irq <= flush_now || err_now || sent_now;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // read port, data stands one cycle after the strobe
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
         rdata_ff <= 8'h00;
      else if (RD)
      begin
         unique case (ADDR)
            `UHEP_ADDR_EP0_CTRL_HI: rdata_ff <= {7'h00, fl_ff != UHEP_F_IDLE};
            `UHEP_ADDR_EP0_COUNT: rdata_ff <= {1'b0, count_ff};
            `UHEP_ADDR_EP0_SPEED: rdata_ff <= {speed_ff, 6'h00};
            `UHEP_ADDR_EP0_NAKLIM: rdata_ff <= {3'h0, naklim_ff};
            `UHEP_ADDR_TX1_CTRL_LO: rdata_ff <= txcsr_ff[0];
            `UHEP_ADDR_TX2_CTRL_LO: rdata_ff <= txcsr_ff[1];
            `UHEP_ADDR_TX3_CTRL_LO: rdata_ff <= txcsr_ff[2];
            default: rdata_ff <= 8'h00;
         endcase
      end
      else
         rdata_ff <= 8'h00;
   end

   // outputs straight from flip-flops
   assign RDATA = rdata_ff;
   assign EP0_FLUSH = flush_ff;
   assign EP0_HALT = halt_ff;
   assign EP0_SPEED = uhep_speed_e'(speed_ff);
   assign TX_CMD = {txcmd_ff[2], txcmd_ff[1], txcmd_ff[0]};

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SRST);

   // endpoint 0 checks
   ep0_flush_pulse_a: assert property (
      wr_ep0hi && WDATA[0] && fl_ff == UHEP_F_IDLE |=> EP0_FLUSH ##1 !EP0_FLUSH)
      else $error("ep0 flush pulse missing");
   ep0_flush_clear_a: assert property (
      fl_ff == UHEP_F_DROP |-> ##2 fl_ff == UHEP_F_IDLE)
      else $error("ep0 flush bit stuck");
   nak_disable_a: assert property (
      naklim_ff < 5'h02 |=> !EP0_HALT)
      else $error("halt with timeout off");
   nak_halt_a: assert property (
      FRAME_TICK && (nak_in_frame_ff || EP0_NAK) && !EP0_ACK && nak_enable && !wr_naklim
      && nak_frames_ff >= nak_limit |=> EP0_HALT)
      else $error("no halt on nak limit");
   count_track_a: assert property (
      ##1 count_ff == $past(EP0_FIFO_LEVEL))
      else $error("count lags fifo");
   rsv_zero_a: assert property (
      RD && ADDR == 9'h10b |=> RDATA[7:5] == 3'h0)
      else $error("reserved bits nonzero");
   // transmit endpoint checks
   stall_set_a: assert property (
      TX_EV[1].stall |=> txcsr_ff[1][5] && !txcsr_ff[1][0] ##1 TX_CMD[1].dma_stop)
      else $error("stall not handled");
   tog_clr_a: assert property (
      WR && ADDR == 9'h112 && WDATA[6] |=> TX_CMD[0].tog_clr)
      else $error("toggle not cleared");
   setup_tog_a: assert property (
      WR && ADDR == 9'h112 && WDATA[4] && WDATA[0] && !TX_EV[0].sent
      |=> TX_CMD[0].tog_clr ##1 TX_CMD[0].setup_tok) else $error("setup token missing");
   flush_irq_a: assert property (
      WR && ADDR == 9'h122 && WDATA[3] |=> TX_CMD[1].flush && TX_CMD[1].irq && !txcsr_ff[1][0])
      else $error("tx flush");
   err_set_a: assert property (
      TX_EV[2].no_hs && TX_EV[2].bulk && retry_ff[2] == 2'h2
      |=> txcsr_ff[2][2] && !txcsr_ff[2][0] && TX_CMD[2].flush && TX_CMD[2].irq)
      else $error("error bit not set");
   nak_expiry_halt_set_a: assert property (
      TX_EV[0].nak && TX_EV[0].bulk && EP0_HALT |=> txcsr_ff[0][7])
      else $error("nak timeout bit not set");
   sent_clr_a: assert property (
      TX_EV[0].sent && txcsr_ff[0][0] && !(WR && ADDR == 9'h112)
      |=> !txcsr_ff[0][0] && TX_CMD[0].irq) else $error("ready not cleared");
   // main scenarios reached

   ep0_flush_c: cover property (wr_ep0hi && WDATA[0] ##3 fl_ff == UHEP_F_IDLE);
   nak_halt_c: cover property (!EP0_HALT ##1 EP0_HALT);
   tx_err_c: cover property (txcsr_ff[0][2] == 1'b0 ##1 txcsr_ff[0][2]);
   tx_sent_c: cover property (TX_CMD[1].irq && !txcsr_ff[1][0]);
endmodule

//--- bench/uhep_target.sv
// far-side model: target device answers and frame timing for the control block
`timescale 1ns/1ps
module uhep_target
(
   input wire logic clk,
   input wire logic srst,
   input wire logic nak_on,
   input wire logic [1:0] ans,
   input wire logic bulk,
   input wire uhep_pkg::uhep_txcmd_s [2:0] cmd,
   output logic frame,
   output logic nak,
   output logic ack,
   output uhep_pkg::uhep_txev_s [2:0] ev,
   output logic [2:0] fifo_ne
);
   import uhep_pkg::*;
   logic [3:0] fcnt; // position inside the 16-cycle frame
   logic [2:0] gap [3]; // cycles since the last attempt per endpoint
   // frame tick every 16 cycles, endpoint 0 answers once per frame, at count 3
   always_ff @(posedge clk)
   begin
      fcnt <= srst ? 4'h0 : fcnt + 4'h1;
      frame <= !srst && fcnt == 4'hf;
      nak <= !srst && nak_on && fcnt == 4'h3;
      ack <= !srst && !nak_on && fcnt == 4'h3;
   end
   // one attempt every eight cycles while a packet waits, answered as told
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < 3; i++)
      begin
         gap[i] <= (srst || !cmd[i].send) ? 3'h0 : gap[i] + 3'h1;
         ev[i].sent <= gap[i] == 3'h7 && ans == 2'h0;
         ev[i].nak <= gap[i] == 3'h7 && ans == 2'h1;
         ev[i].stall <= gap[i] == 3'h7 && ans == 2'h2;
         ev[i].no_hs <= gap[i] == 3'h7 && ans == 2'h3;
         ev[i].bulk <= bulk;
         ev[i].intr <= 1'b0;
         fifo_ne[i] <= cmd[i].send;
      end
   end
endmodule

//--- bench/uhep_ctrl_test.sv
// self-checking bench for the host endpoint 0 and transmit endpoint control block
`timescale 1ns/1ps
`include "uhep_defs.svh"
module uhep_ctrl_test;
   import uhep_pkg::*;
   localparam logic [8:0] a_hi = `UHEP_ADDR_EP0_CTRL_HI;
   localparam logic [8:0] a_cnt = `UHEP_ADDR_EP0_COUNT;
   localparam logic [8:0] a_spd = `UHEP_ADDR_EP0_SPEED;
   localparam logic [8:0] a_lim = `UHEP_ADDR_EP0_NAKLIM;
   localparam logic [8:0] a_tx1 = `UHEP_ADDR_TX1_CTRL_LO;
   localparam logic [8:0] a_tx2 = `UHEP_ADDR_TX2_CTRL_LO;
   localparam logic [8:0] a_tx3 = `UHEP_ADDR_TX3_CTRL_LO;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic [8:0] addr = 9'h000;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [6:0] fifo_lvl = 7'h00;
   logic rx_rdy = 1'b0;
   logic nak_on = 1'b0; // far side keeps answering nak on endpoint 0
   logic [1:0] ans = 2'h0; // far side answer to transmit attempts
   logic bulk = 1'b0;
   logic [7:0] rdata, d;
   logic [8:0] a;
   logic ep0_nak, ep0_ack, frame, ep0_flush, ep0_halt;
   uhep_speed_e ep0_speed;
   uhep_txev_s [2:0] tx_ev;
   logic [2:0] tx_ne;
   uhep_txcmd_s [2:0] tx_cmd;
   logic [2:0] irq_seen = 3'h0; // sticky record of interrupt pulses
   logic [2:0] fl_seen = 3'h0; // sticky record of flush pulses
   int n_mismatch = 0;
   int check_count = 0;
   always #4 clk_sys = ~clk_sys;
   uhep_ctrl i_uhep_ctrl (.CLK_SYS(clk_sys), .SRST(srst), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .EP0_FIFO_LEVEL(fifo_lvl), .EP0_TX_READY(rx_rdy),
      .EP0_RX_READY(rx_rdy), .EP0_NAK(ep0_nak), .EP0_ACK(ep0_ack), .FRAME_TICK(frame),
      .EP0_FLUSH(ep0_flush), .EP0_HALT(ep0_halt), .EP0_SPEED(ep0_speed), .TX_EV(tx_ev),
      .TX_FIFO_NONEMPTY(tx_ne), .TX_CMD(tx_cmd));
   uhep_target i_uhep_target (.clk(clk_sys), .srst(srst), .nak_on(nak_on), .ans(ans),
      .bulk(bulk), .cmd(tx_cmd), .frame(frame), .nak(ep0_nak), .ack(ep0_ack), .ev(tx_ev),
      .fifo_ne(tx_ne));
   // catch one-cycle pulses so slow polling cannot miss them
   always @(posedge clk_sys)
   begin
      for (int i = 0; i < 3; i++)
      begin
         if (tx_cmd[i].irq === 1'b1) irq_seen[i] <= 1'b1;
         if (tx_cmd[i].flush === 1'b1) fl_seen[i] <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // compare one byte
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   // one-cycle write strobe, returns 1 ns after the sampling edge
   task automatic bus_wr(input logic [8:0] a_i, input logic [7:0] d_i);
      @(posedge clk_sys);
      addr <= a_i;
      wdata <= d_i;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      #1;
   endtask
   // one-cycle read strobe, data taken in the following cycle only
   task automatic bus_rd(input logic [8:0] a_i);
      @(posedge clk_sys);
      addr <= a_i;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic rcm(input logic [8:0] a_i, input logic [7:0] m, input logic [7:0] e);
      bus_rd(a_i);
      chk(d & m, e);
   endtask
   // poll a register until masked bits match, bounded
   task automatic wait_bit(input logic [8:0] a_i, input logic [7:0] m, input logic [7:0] e);
      int n = 0;
      bus_rd(a_i);
      while ((d & m) !== e && n < 60)
      begin
         bus_rd(a_i);
         n++;
      end
      chk(d & m, e);
      if (n >= 60) end_of_test();
   endtask
   // set the far-side behaviour and clear the pulse records
   task automatic set_far(input logic [1:0] an, input logic bk, input logic nk);
      @(posedge clk_sys);
      ans <= an;
      bulk <= bk;
      nak_on <= nk;
      irq_seen = 3'h0;
      fl_seen = 3'h0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk({6'h00, ep0_flush, ep0_halt}, 8'h00);
   endtask
   task automatic t_regs0();
      logic [8:0] tbl [8] = '{a_hi, a_cnt, a_spd, a_lim, a_tx1, a_tx2, a_tx3, 9'h100};
      for (int k = 0; k < 8; k++) rcm(tbl[k], 8'hff, 8'h00);
   endtask
   task automatic t_count();
      @(posedge clk_sys);
      fifo_lvl <= 7'h5a;
      rx_rdy <= 1'b1;
      rcm(a_cnt, 8'hff, 8'h5a);
      @(posedge clk_sys);
      fifo_lvl <= 7'h7f;
      bus_wr(a_cnt, 8'h00);
      rcm(a_cnt, 8'hff, 8'h7f);
   endtask
   task automatic t_ep0_flush();
      bus_wr(a_hi, 8'hff);
      chk({7'h00, ep0_flush}, 8'h01);
      rcm(a_hi, 8'h01, 8'h01);
      repeat (4) @(posedge clk_sys);
      #1;
      chk({7'h00, ep0_flush}, 8'h00);
      rcm(a_hi, 8'hff, 8'h00);
   endtask
   task automatic t_speed();
      for (int j = 0; j < 4; j++)
      begin
         bus_wr(a_spd, {j[1:0], 6'h3f});
         rcm(a_spd, 8'hff, {j[1:0], 6'h00});
         chk({6'h00, ep0_speed}, {6'h00, j[1:0]});
      end
   endtask
   task automatic t_tx_flush_tog();
      for (int i = 0; i < 3; i++)
      begin
         a = a_tx1 + `UHEP_ADDR_TX_STRIDE * i[8:0];
         bus_wr(a, 8'h09);
         chk({6'h00, tx_cmd[i].flush, tx_cmd[i].irq}, 8'h03);
         rcm(a, 8'h01, 8'h00);
         bus_wr(a, 8'h40);
         chk({7'h00, tx_cmd[i].tog_clr}, 8'h01);
      end
   endtask
   task automatic t_setup_sent();
      set_far(2'h0, 1'b0, 1'b0);
      bus_wr(a_tx1, 8'h11);
      chk({7'h00, tx_cmd[0].tog_clr}, 8'h01);
      @(posedge clk_sys);
      #1;
      chk({7'h00, tx_cmd[0].setup_tok}, 8'h01);
      wait_bit(a_tx1, 8'h01, 8'h00);
      chk({7'h00, irq_seen[0]}, 8'h01);
   endtask
   task automatic t_stall();
      set_far(2'h2, 1'b0, 1'b0);
      bus_wr(a_tx2, 8'h01);
      wait_bit(a_tx2, 8'h21, 8'h20);
      chk({6'h00, tx_cmd[1].dma_stop, tx_cmd[1].send}, 8'h02);
      chk({7'h00, fl_seen[1]}, 8'h01);
      bus_wr(a_tx2, 8'h00);
      rcm(a_tx2, 8'h20, 8'h00);
   endtask
   task automatic t_error();
      set_far(2'h3, 1'b1, 1'b0);
      bus_wr(a_tx3, 8'h01);
      repeat (10) @(posedge clk_sys);
      rcm(a_tx3, 8'h04, 8'h00);
      wait_bit(a_tx3, 8'h05, 8'h04);
      chk({6'h00, irq_seen[2], fl_seen[2]}, 8'h03);
      bus_wr(a_tx3, 8'h00);
   endtask
   task automatic t_nak();
      int n = 0;
      set_far(2'h1, 1'b1, 1'b1);
      bus_wr(a_lim, 8'h01);
      repeat (160) @(posedge clk_sys);
      #1;
      chk({7'h00, ep0_halt}, 8'h00);
      bus_wr(a_lim, 8'he3);
      rcm(a_lim, 8'hff, 8'h03);
      repeat (40) @(posedge clk_sys);
      #1;
      chk({7'h00, ep0_halt}, 8'h00);
      while (ep0_halt !== 1'b1 && n < 60)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk({7'h00, ep0_halt}, 8'h01);
      if (n >= 60) end_of_test();
      bus_wr(a_tx1, 8'h01);
      wait_bit(a_tx1, 8'h80, 8'h80);
      bus_wr(a_tx1, 8'h00);
      rcm(a_tx1, 8'h81, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      #1;
      t_reset();
      t_regs0();
      t_count();
      t_ep0_flush();
      t_speed();
      t_tx_flush_tog();
      t_setup_sent();
      t_stall();
      t_error();
      t_nak();
      end_of_test();
   end
endmodule
